//--- hw/wdtp_map.svh
// Constants for the watchdog time-out prescaler: offsets, fields, timing.
// Assumes a single 10 MHz system clock and word-wide AHB-Lite access.
// Overview of operation
// - When running, expire after 512 to 256K oscillator ticks chosen by code.
// - Select field sits at control bit 5 (msb) and bits 2:0.
// - Reserved select codes 1010 to 1111 fall back to a valid period.
// - Select write is accepted only within four cycles after the signature.
// - Reset-mode expiry restarts execution from program address 0x0000.
// - The count advances on the 32kHz oscillator tick, not the system clock.
// - Count clears on restart, on disable and on any chip reset.
// - Expiry with enable and interrupt enable raises interrupt, clears irq enable.
// - Time-out flag clears when its vector executes or on write of one.
`ifndef WDTP_MAP_SVH
`define WDTP_MAP_SVH

`define WDTP_CLK_HZ 10000000
`define WDTP_OSC_HZ 32000
`define WDTP_BASE_TICKS 512
`define WDTP_UNLOCK_CYCLES 3'h4
`define WDTP_CCP_SIG 8'hD8
`define WDTP_SIG_W 8
`define WDTP_RESET_VECTOR 16'h0000

`define WDTP_CNT_W 19
`define WDTP_DIV_W 9
`define WDTP_WIN_W 3
`define WDTP_ADDR_W 12

`define WDTP_OFF_CCP 12'h034
`define WDTP_OFF_CTRL 12'h060
`define WDTP_OFF_ISTAT 12'h064
`define WDTP_OFF_IMASK 12'h068
`define WDTP_OFF_RESTART 12'h06C
`define WDTP_OFF_COUNT 12'h070

`define WDTP_BIT_FLAG 7
`define WDTP_BIT_IRQEN 6
`define WDTP_BIT_SELMSB 5
`define WDTP_BIT_EN 3
`define WDTP_SEL_HI 2
`define WDTP_SEL_LO 0

`define WDTP_EV_IRQ 0
`define WDTP_EV_RST 1
`define WDTP_EV_W 2

`define WDTP_SEL_LAST 4'h9
`define WDTP_SEL_FIRST_RSV 4'hA

`define WDTP_HTRANS_BIT 1

`endif

//--- hw/wdtp_pkg.sv
// Types shared by the watchdog time-out prescaler modules.
// Assumes the constants header is on the include path.
`include "wdtp_map.svh"

package wdtp_pkg;

    typedef struct packed {
        logic flag;
        logic irq_en;
        logic [3:0] sel;
        logic en;
    } wdtp_ctrl_s;

    typedef struct packed {
        wdtp_ctrl_s ctrl;
        logic [`WDTP_WIN_W-1:0] ccp_win;
        logic [`WDTP_DIV_W-1:0] div;
        logic [`WDTP_CNT_W-1:0] cnt;
        logic [`WDTP_EV_W-1:0] istat;
        logic [`WDTP_EV_W-1:0] imask;
        logic rst_pulse;
        logic [15:0] vec;
        logic wr_pend;
        logic [`WDTP_ADDR_W-1:0] wr_addr;
        logic [31:0] rdata;
    } wdtp_state_s;

    typedef struct packed {
        logic [`WDTP_CNT_W-1:0] limit;
    } wdtp_per_s;

endpackage : wdtp_pkg

//--- hw/wdtp_period.sv
// Decodes the time-out select code into a registered period in ticks.
// Assumes the select code comes from logic on the same clock.
`timescale 1ns/1ps
`include "wdtp_map.svh"

module wdtp_period
    import wdtp_pkg::*;
#(
    parameter int BASE_TICKS = `WDTP_BASE_TICKS
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [3:0] timeout_select_in,
    output logic [`WDTP_CNT_W-1:0] period_ticks_out
);

    wdtp_per_s s;
    wdtp_per_s next_s;
    logic [3:0] eff_sel;

    always_comb begin
        eff_sel = timeout_select_in;
        if (timeout_select_in >= `WDTP_SEL_FIRST_RSV) begin
            eff_sel = `WDTP_SEL_LAST;
        end
        next_s.limit = `WDTP_CNT_W'(BASE_TICKS) << eff_sel;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign period_ticks_out = s.limit;

endmodule : wdtp_period

//--- hw/wdtp_top.sv
// Watchdog time-out prescaler with protected select change, AHB-Lite slave.
// Assumes zero-wait single word transfers and same-clock CPU event inputs.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "wdtp_map.svh"

module wdtp_top
    import wdtp_pkg::*;
#(
    parameter int OSC_DIV = `WDTP_CLK_HZ / `WDTP_OSC_HZ,
    parameter int BASE_TICKS = `WDTP_BASE_TICKS
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic restart_in,
    input wire logic vector_ack_in,
    output logic guard_timeout_out,
    output logic chip_reset_out,
    output logic [15:0] reset_vector_out,
    output logic irq_out
);

    localparam int CW = `WDTP_CNT_W;
    localparam int DW = `WDTP_DIV_W;
    localparam int WW = `WDTP_WIN_W;

    wdtp_state_s s;
    wdtp_state_s next_s;
    logic [CW-1:0] limit;
    logic take;
    logic unlocked;
    logic restart_wr;
    logic running;
    logic tick;
    logic clr;
    logic expire;

    wdtp_period #(
        .BASE_TICKS(BASE_TICKS)
    ) u_period (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .timeout_select_in(s.ctrl.sel),
        .period_ticks_out(limit)
    );

    function automatic logic [31:0] rd_word(
        input logic [`WDTP_ADDR_W-1:0] a,
        input wdtp_state_s st
    );
        logic [31:0] w;
        w = '0;
        case (a)
            `WDTP_OFF_CTRL: begin
                w[`WDTP_BIT_FLAG] = st.ctrl.flag;
                w[`WDTP_BIT_IRQEN] = st.ctrl.irq_en;
                w[`WDTP_BIT_SELMSB] = st.ctrl.sel[3];
                w[`WDTP_BIT_EN] = st.ctrl.en;
                w[`WDTP_SEL_HI:`WDTP_SEL_LO] = st.ctrl.sel[2:0];
            end
            `WDTP_OFF_ISTAT: w[`WDTP_EV_W-1:0] = st.istat;
            `WDTP_OFF_IMASK: w[`WDTP_EV_W-1:0] = st.imask;
            `WDTP_OFF_COUNT: w[CW-1:0] = st.cnt;
            default: w = '0;
        endcase
        return w;
    endfunction : rd_word

    always_comb begin
        next_s = s;
        next_s.rst_pulse = 1'b0;
        restart_wr = 1'b0;
        take = hsel_in && hready_in && htrans_in[`WDTP_HTRANS_BIT];
        unlocked = (s.ccp_win != '0);
        next_s.ccp_win = unlocked ? WW'(s.ccp_win - 1'b1) : '0;

        // Address phase: capture the write target, or fetch read data now
        // so that it stands registered throughout the data phase.
        next_s.wr_pend = 1'b0;
        if (take) begin
            next_s.wr_pend = hwrite_in;
            next_s.wr_addr = haddr_in[`WDTP_ADDR_W-1:0];
            if (!hwrite_in) begin
                next_s.rdata = rd_word(haddr_in[`WDTP_ADDR_W-1:0], s);
            end
        end

        // Data phase: writes land here.
        if (s.wr_pend) begin
            case (s.wr_addr)
                `WDTP_OFF_CCP: begin
                    if (hwdata_in[`WDTP_SIG_W-1:0] == `WDTP_CCP_SIG) begin
                        next_s.ccp_win = `WDTP_UNLOCK_CYCLES;
                    end
                end
                `WDTP_OFF_CTRL: begin
                    if (hwdata_in[`WDTP_BIT_FLAG]) begin
                        next_s.ctrl.flag = 1'b0;
                    end
                    next_s.ctrl.irq_en = hwdata_in[`WDTP_BIT_IRQEN];
                    if (unlocked) begin
                        next_s.ctrl.sel = {hwdata_in[`WDTP_BIT_SELMSB],
                            hwdata_in[`WDTP_SEL_HI:`WDTP_SEL_LO]};
                        next_s.ctrl.en = hwdata_in[`WDTP_BIT_EN];
                        next_s.ccp_win = '0;
                    end else begin
                        // Enabling is free; disabling needs the unlock.
                        next_s.ctrl.en = s.ctrl.en | hwdata_in[`WDTP_BIT_EN];
                    end
                end
                `WDTP_OFF_ISTAT: begin
                    next_s.istat = s.istat & ~hwdata_in[`WDTP_EV_W-1:0];
                end
                `WDTP_OFF_IMASK: begin
                    next_s.imask = hwdata_in[`WDTP_EV_W-1:0];
                end
                `WDTP_OFF_RESTART: restart_wr = 1'b1;
                default: ;
            endcase
        end

        if (vector_ack_in) begin
            next_s.ctrl.flag = 1'b0;
        end

        // Oscillator tick divider and time-out counter.
        running = s.ctrl.en | s.ctrl.irq_en;
        clr = !running || restart_in || restart_wr;
        tick = (s.div == DW'(OSC_DIV - 1));
        expire = tick && !clr && (s.cnt == CW'(limit - 1'b1));
        if (clr) begin
            next_s.div = '0;
            next_s.cnt = '0;
        end else begin
            next_s.div = tick ? '0 : DW'(s.div + 1'b1);
            if (tick) begin
                next_s.cnt = expire ? '0 : CW'(s.cnt + 1'b1);
            end
        end

        // Events are applied last so a set beats any clear in this cycle.
        if (expire) begin
            if (s.ctrl.irq_en) begin
                next_s.ctrl.flag = 1'b1;
                next_s.istat[`WDTP_EV_IRQ] = 1'b1;
                if (s.ctrl.en) begin
                    next_s.ctrl.irq_en = 1'b0;
                end
            end else begin
                next_s.rst_pulse = 1'b1;
                next_s.vec = `WDTP_RESET_VECTOR;
                next_s.istat[`WDTP_EV_RST] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = s.rdata;
    assign guard_timeout_out = s.ctrl.flag;
    assign chip_reset_out = s.rst_pulse;
    assign reset_vector_out = s.vec;
    assign irq_out = |(s.istat & s.imask);

    property p_count_step;
        @(posedge clk_in) disable iff (!nrst_in)
        (tick && !clr && !expire) |=> (s.cnt == CW'($past(s.cnt) + 1'b1));
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("Count did not advance by one on a tick.");

    property p_expire_wrap;
        @(posedge clk_in) disable iff (!nrst_in)
        expire |=> (s.cnt == '0) && (s.ctrl.flag || s.rst_pulse);
    endproperty
    a_expire_wrap: assert property (p_expire_wrap)
        else $error("Expiry did not clear the count or signal an action.");

    property p_select_readback;
        @(posedge clk_in) disable iff (!nrst_in)
        (take && !hwrite_in &&
            haddr_in[`WDTP_ADDR_W-1:0] == `WDTP_OFF_CTRL)
        |=> (hrdata_out[`WDTP_BIT_SELMSB] == $past(s.ctrl.sel[3])) &&
            (hrdata_out[`WDTP_SEL_HI:`WDTP_SEL_LO] ==
                $past(s.ctrl.sel[2:0]));
    endproperty
    a_select_readback: assert property (p_select_readback)
        else $error("Select bits read back at the wrong positions.");

    property p_reserved_fallback;
        @(posedge clk_in) disable iff (!nrst_in)
        ($past(s.ctrl.sel) >= `WDTP_SEL_FIRST_RSV)
        |-> (limit == (CW'(BASE_TICKS) << `WDTP_SEL_LAST));
    endproperty
    a_reserved_fallback: assert property (p_reserved_fallback)
        else $error("Reserved select code did not use the longest period.");

    property p_locked_select;
        @(posedge clk_in) disable iff (!nrst_in)
        (s.wr_pend && s.wr_addr == `WDTP_OFF_CTRL && s.ccp_win == '0)
        |=> $stable(s.ctrl.sel);
    endproperty
    a_locked_select: assert property (p_locked_select)
        else $error("Select changed without the unlock window.");

    property p_unlocked_select;
        @(posedge clk_in) disable iff (!nrst_in)
        (s.wr_pend && s.wr_addr == `WDTP_OFF_CCP &&
            hwdata_in[`WDTP_SIG_W-1:0] == `WDTP_CCP_SIG)
        |=> (s.ccp_win == `WDTP_UNLOCK_CYCLES);
    endproperty
    a_unlocked_select: assert property (p_unlocked_select)
        else $error("Signature write did not open a four-cycle window.");

    property p_window_count;
        @(posedge clk_in) disable iff (!nrst_in)
        (s.ccp_win != '0 && !(s.wr_pend &&
            (s.wr_addr == `WDTP_OFF_CCP || s.wr_addr == `WDTP_OFF_CTRL)))
        |=> (s.ccp_win == WW'($past(s.ccp_win) - 1'b1));
    endproperty
    a_window_count: assert property (p_window_count)
        else $error("Unlock window did not count down by one.");

    property p_unlocked_accept;
        @(posedge clk_in) disable iff (!nrst_in)
        (s.wr_pend && s.wr_addr == `WDTP_OFF_CTRL && s.ccp_win != '0)
        |=> (s.ctrl.sel == {$past(hwdata_in[`WDTP_BIT_SELMSB]),
            $past(hwdata_in[`WDTP_SEL_HI:`WDTP_SEL_LO])}) &&
            (s.ccp_win == '0);
    endproperty
    a_unlocked_accept: assert property (p_unlocked_accept)
        else $error("Unlocked control write did not take the select bits.");

    property p_flag_w1c;
        @(posedge clk_in) disable iff (!nrst_in)
        (s.wr_pend && s.wr_addr == `WDTP_OFF_CTRL &&
            hwdata_in[`WDTP_BIT_FLAG] && !expire)
        |=> !guard_timeout_out;
    endproperty
    a_flag_w1c: assert property (p_flag_w1c)
        else $error("Writing one did not clear the time-out flag.");

    property p_reset_mode;
        @(posedge clk_in) disable iff (!nrst_in)
        (expire && !s.ctrl.irq_en) |=> chip_reset_out;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("Reset-mode expiry did not request a chip reset.");

    property p_reset_vector;
        @(posedge clk_in) disable iff (!nrst_in)
        chip_reset_out |-> (reset_vector_out == `WDTP_RESET_VECTOR) &&
            s.istat[`WDTP_EV_RST];
    endproperty
    a_reset_vector: assert property (p_reset_vector)
        else $error("Watchdog reset did not point at the reset vector.");

    property p_tick_only;
        @(posedge clk_in) disable iff (!nrst_in)
        (!tick && !clr) |=> $stable(s.cnt);
    endproperty
    a_tick_only: assert property (p_tick_only)
        else $error("Count moved without an oscillator tick.");

    property p_restart_clear;
        @(posedge clk_in) disable iff (!nrst_in)
        (restart_in || !running) |=> (s.cnt == '0);
    endproperty
    a_restart_clear: assert property (p_restart_clear)
        else $error("Restart or disable did not clear the count.");

    property p_irq_then_reset;
        @(posedge clk_in) disable iff (!nrst_in)
        (expire && s.ctrl.en && s.ctrl.irq_en)
        |=> s.ctrl.flag && !s.ctrl.irq_en && !chip_reset_out;
    endproperty
    a_irq_then_reset: assert property (p_irq_then_reset)
        else $error("Interrupt expiry did not drop the interrupt enable.");

    property p_flag_clear;
        @(posedge clk_in) disable iff (!nrst_in)
        (vector_ack_in && !expire) |=> !guard_timeout_out;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("Vector execution did not clear the time-out flag.");

endmodule : wdtp_top

//--- test/watchdog_timeout_prescaler_test.sv
// Self-checking bench for the watchdog time-out prescaler top module.
// Assumes the design files under hw/ and one 10 MHz clock, no partner.
`timescale 1ns/1ps
`include "wdtp_map.svh"

module watchdog_timeout_prescaler_test;

    localparam int OSC = 1;
    localparam int BASE = 2;
    localparam int TMO = 4000;

    typedef struct {
        logic [3:0] sel;
        int ticks;
    } wdtp_row_s;

    logic clk_in, nrst_in, hsel_in, hwrite_in, restart_in, vector_ack_in;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
    logic [1:0] htrans_in;
    logic [2:0] hsize_in;
    logic hreadyout_out, hresp_out, guard_timeout_out, chip_reset_out;
    logic irq_out, rs;
    logic [15:0] reset_vector_out;
    int n_errors, comparisons, n;
    wdtp_row_s rows [16];

    wdtp_top #(.OSC_DIV(OSC), .BASE_TICKS(BASE)) wdtp_top_inst (
        .clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
        .hsize_in(hsize_in), .hwdata_in(hwdata_in),
        .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out), .hrdata_out(hrdata_out),
        .restart_in(restart_in), .vector_ack_in(vector_ack_in),
        .guard_timeout_out(guard_timeout_out),
        .chip_reset_out(chip_reset_out),
        .reset_vector_out(reset_vector_out), .irq_out(irq_out)
    );

    task automatic end_of_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                            input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_word({31'h0, got}, {31'h0, exp}, what);
    endtask : chk_bit

    // Waits for the ready sampled high at a rising edge, with a bound.
    task automatic wait_rdy;
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_in);
            if (hreadyout_out === 1'b1) begin
                break;
            end
        end
        if (i == 20) begin
            n_errors++;
            $display("MISMATCH t=%0t bus ready never came", $time);
            end_of_test();
        end
    endtask : wait_rdy

    // One single word transfer; called right after a rising edge.
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        hwrite_in <= wr;
        haddr_in <= {20'h0, a};
        hsize_in <= 3'h2;
        wait_rdy();
        htrans_in <= 2'h0;
        hwdata_in <= wr ? d : 32'h0;
        wait_rdy();
        rd = hrdata_out;
        chk_bit(hresp_out, 1'b0, "okay response");
    endtask : bus

    task automatic unlock_ctrl(input logic [31:0] v);
        bus(1'b1, `WDTP_OFF_CCP, 32'h0000_00D8);
        bus(1'b1, `WDTP_OFF_CTRL, v);
    endtask : unlock_ctrl

    // Counts whole cycles before an expiry shows, then realigns to a rise.
    task automatic wait_exp(output int cnt, output logic was_rst);
        cnt = 0;
        was_rst = 1'b0;
        while (cnt < TMO) begin
            @(negedge clk_in);
            if (chip_reset_out === 1'b1 || guard_timeout_out === 1'b1) begin
                break;
            end
            cnt++;
        end
        was_rst = chip_reset_out;
        if (cnt >= TMO) begin
            n_errors++;
            $display("MISMATCH t=%0t no expiry seen", $time);
            end_of_test();
        end
        @(posedge clk_in);
    endtask : wait_exp

    function automatic logic [31:0] cw(input logic [3:0] s, input logic en,
                                       input logic ie);
        return {24'h0, 1'b0, ie, s[3], 1'b0, en, s[2:0]};
    endfunction : cw

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    initial begin
        {nrst_in, hsel_in, hwrite_in, restart_in, vector_ack_in} = 5'h00;
        {haddr_in, hwdata_in, htrans_in, hsize_in} = 69'h0;
        n_errors = 0;
        comparisons = 0;
        for (int s = 0; s < 16; s++) begin
            rows[s].sel = 4'(s);
            rows[s].ticks = BASE << (s > 9 ? 9 : s);
        end
        repeat (16) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        bus(1'b0, `WDTP_OFF_CTRL, 32'h0);
        chk_word(rd, 32'h0, "ctrl after reset");
        bus(1'b0, `WDTP_OFF_COUNT, 32'h0);
        chk_word(rd, 32'h0, "count after reset");
        bus(1'b0, 12'hFFC, 32'h0);
        chk_word(rd, 32'h0, "unmapped read");
        for (int r = 0; r < 16; r++) begin
            unlock_ctrl(cw(rows[r].sel, 1'b0, 1'b0));
            bus(1'b0, `WDTP_OFF_CTRL, 32'h0);
            chk_word(rd, cw(rows[r].sel, 1'b0, 1'b0), "select field");
            bus(1'b1, `WDTP_OFF_CTRL, cw(rows[r].sel, 1'b1, 1'b0));
            wait_exp(n, rs);
            chk_word(32'(n), 32'(rows[r].ticks), "period");
            chk_bit(rs, 1'b1, "reset mode expiry");
            chk_word({16'h0, reset_vector_out}, 32'h0, "restart address");
        end
        unlock_ctrl(32'h0);
        bus(1'b0, `WDTP_OFF_ISTAT, 32'h0);
        chk_word(rd, 32'h2, "reset event status");
        chk_bit(irq_out, 1'b0, "masked event");
        bus(1'b1, `WDTP_OFF_IMASK, 32'h2);
        @(negedge clk_in);
        chk_bit(irq_out, 1'b1, "unmasked event");
        @(posedge clk_in);
        bus(1'b1, `WDTP_OFF_ISTAT, 32'h2);
        @(negedge clk_in);
        chk_bit(irq_out, 1'b0, "status cleared");
        @(posedge clk_in);
        bus(1'b1, `WDTP_OFF_CCP, 32'h0000_00D8);
        repeat (2) @(posedge clk_in);
        bus(1'b1, `WDTP_OFF_CTRL, cw(4'h3, 1'b0, 1'b0));
        bus(1'b0, `WDTP_OFF_CTRL, 32'h0);
        chk_word(rd, cw(4'h3, 1'b0, 1'b0), "late edge of window");
        bus(1'b1, `WDTP_OFF_CCP, 32'h0000_00D8);
        repeat (3) @(posedge clk_in);
        bus(1'b1, `WDTP_OFF_CTRL, cw(4'h5, 1'b0, 1'b0));
        bus(1'b0, `WDTP_OFF_CTRL, 32'h0);
        chk_word(rd, cw(4'h3, 1'b0, 1'b0), "write after window");
        bus(1'b1, `WDTP_OFF_IMASK, 32'h1);
        bus(1'b1, `WDTP_OFF_CTRL, cw(4'h3, 1'b1, 1'b1));
        wait_exp(n, rs);
        chk_word(32'(n), 32'd16, "interrupt period");
        chk_bit(rs, 1'b0, "interrupt instead of reset");
        bus(1'b0, `WDTP_OFF_CTRL, 32'h0);
        chk_word(rd, 32'h80 | cw(4'h3, 1'b1, 1'b0), "irq enable dropped");
        chk_bit(irq_out, 1'b1, "interrupt line");
        vector_ack_in <= 1'b1;
        @(posedge clk_in);
        vector_ack_in <= 1'b0;
        @(posedge clk_in);
        chk_bit(guard_timeout_out, 1'b0, "flag cleared by vector");
        wait_exp(n, rs);
        chk_bit(rs, 1'b1, "second expiry resets");
        unlock_ctrl(cw(4'h3, 1'b0, 1'b1));
        wait_exp(n, rs);
        chk_bit(guard_timeout_out, 1'b1, "flag in interrupt mode");
        bus(1'b1, `WDTP_OFF_CTRL, 32'h80 | cw(4'h3, 1'b0, 1'b0));
        @(negedge clk_in);
        chk_bit(guard_timeout_out, 1'b0, "flag cleared by one");
        @(posedge clk_in);
        bus(1'b1, `WDTP_OFF_ISTAT, 32'h3);
        @(negedge clk_in);
        chk_bit(irq_out, 1'b0, "interrupt status cleared");
        @(posedge clk_in);
        bus(1'b1, `WDTP_OFF_CTRL, cw(4'h3, 1'b1, 1'b0));
        repeat (10) @(posedge clk_in);
        restart_in <= 1'b1;
        @(posedge clk_in);
        restart_in <= 1'b0;
        wait_exp(n, rs);
        chk_word(32'(n), 32'd16, "period after restart");
        repeat (5) @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        bus(1'b0, `WDTP_OFF_CTRL, 32'h0);
        chk_word(rd, 32'h0, "ctrl after mid-run reset");
        bus(1'b0, `WDTP_OFF_COUNT, 32'h0);
        chk_word(rd, 32'h0, "count after mid-run reset");
        chk_bit(irq_out, 1'b0, "interrupt after mid-run reset");
        chk_bit(chip_reset_out, 1'b0, "reset request after mid-run reset");
        end_of_test();
    end

endmodule : watchdog_timeout_prescaler_test
